/* sacc_pkg.sv */
package sacc_pkg;

   // timing base
   localparam int CLK_PERIOD_NS = 10;
   localparam int CONV_TIME_NS = 1500;
   localparam int ACQ_START_NS = 527;
   localparam int POR_WAIT_US = 20;

   // longest time rounds down, least time rounds up
   localparam logic [7:0] CONV_CYCLES = 8'(CONV_TIME_NS / CLK_PERIOD_NS);
   localparam logic [7:0] ACQ_START_CYCLES = 8'((ACQ_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [10:0] POR_WAIT_CYCLES = 11'((POR_WAIT_US * 1000) / CLK_PERIOD_NS);

   // code limits, two's complement
   localparam logic [15:0] CODE_POS_FS = 16'h7FFF;
   localparam logic [15:0] CODE_NEG_FS = 16'h8000;
   localparam logic signed [17:0] SUM_POS_FS = 18'sh07FFF;
   localparam logic signed [17:0] SUM_NEG_FS = 18'sh38000;

   typedef enum logic [0:0] {
      ST_DOWN = 1'b0,
      ST_CONV = 1'b1
   } sacc_state_t;

   typedef struct packed {
      logic [15:0] data;
      logic valid;
   } sacc_result_t;

   // reset values
   localparam sacc_result_t RESULT_RST = '{data: 16'h0000, valid: 1'b0};
   localparam logic [7:0] CONV_CNT_RST = 8'h00;
   localparam logic [10:0] INIT_CNT_RST = 11'h000;

endpackage

/* sacc_ctrl.sv */
`timescale 1ns/100ps
// Contract
// - select low: full scale spans 10%-90% range
// - reset at power-up or brownout, then reinitialise
// - strobe rising edge powers core, starts conversion
// - edges during conversion never restart it
// - busy high exactly while converting
// - after conversion: power down, acquire again
// - conversion and busy finish within 1.5us
// - acquisition restarts 527ns after conversion start
// - result is 16-bit two's complement code
module sacc_ctrl
   import sacc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // conversion control pins
   input wire logic convert_strobe,
   input wire logic gain_compress_select,
   // sampled input code from the front end
   input wire logic [15:0] sample_code,
   // status
   output logic busy,
   output logic core_powered,
   output logic acquiring,
   output logic init_done,
   // conversion result for readout
   output sacc_result_t result
);

   // pin synchronisers
   logic cnv_s1_r;
   logic cnv_s2_r;
   logic cnv_s3_r;
   logic sel_s1_r;
   logic sel_s2_r;
   logic cnv_rise;

   // conversion state
   sacc_state_t state_r;
   sacc_state_t state_nxt;
   logic [7:0] conv_cnt_r;
   logic conv_done;
   logic conv_start;
   logic [15:0] held_code_r;
   logic held_sel_r;
   logic start_valid_r;
   logic [10:0] init_cnt_r;
   logic init_done_r;
   logic [15:0] conv_code;
   logic signed [17:0] code_ext;
   logic signed [17:0] code_scaled;
   sacc_result_t result_r;

   // first stage is read by the second stage only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnv_s1_r <= 1'b0;
         cnv_s2_r <= 1'b0;
         cnv_s3_r <= 1'b0;
      end else begin
         cnv_s1_r <= convert_strobe;
         cnv_s2_r <= cnv_s1_r;
         cnv_s3_r <= cnv_s2_r;
      end
   end

   // idles high so compression stays off until the pin is seen low
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sel_s1_r <= 1'b1;
         sel_s2_r <= 1'b1;
      end else begin
         sel_s1_r <= gain_compress_select;
         sel_s2_r <= sel_s1_r;
      end
   end

   assign cnv_rise = cnv_s2_r & ~cnv_s3_r;
   assign conv_done = (state_r == ST_CONV) && (conv_cnt_r == CONV_CYCLES - 8'h01);
   assign conv_start = (state_r == ST_DOWN) && cnv_rise;

   // edges while converting fall through: no restart path exists
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_DOWN: begin
            if (cnv_rise) begin
               state_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               state_nxt = ST_DOWN;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_DOWN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // internally timed conversion
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         conv_cnt_r <= CONV_CNT_RST;
      end else if (conv_start) begin
         conv_cnt_r <= CONV_CNT_RST;
      end else if (state_r == ST_CONV && !conv_done) begin
         conv_cnt_r <= conv_cnt_r + 8'h01;
      end
   end

   // sample and mode held for the whole conversion
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         held_code_r <= 16'h0000;
         held_sel_r <= 1'b1;
         start_valid_r <= 1'b0;
      end else if (conv_start) begin
         held_code_r <= sample_code;
         held_sel_r <= sel_s2_r;
         start_valid_r <= init_done_r;
      end
   end

   // power-on wait; rst is the supply monitor's reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         init_cnt_r <= INIT_CNT_RST;
         init_done_r <= 1'b0;
      end else if (!init_done_r) begin
         if (init_cnt_r == POR_WAIT_CYCLES - 11'h001) begin
            init_done_r <= 1'b1;
         end
         init_cnt_r <= init_cnt_r + 11'h001;
      end
   end

   // compression: scale by 5/4 so 10%-90% input reaches full scale
   assign code_ext = {{2{held_code_r[15]}}, held_code_r};
   assign code_scaled = code_ext + (code_ext >>> 2);

   always_comb begin
      conv_code = held_code_r;
      if (!held_sel_r) begin
         if (code_scaled > SUM_POS_FS) begin
            conv_code = CODE_POS_FS;
         end else if (code_scaled < SUM_NEG_FS) begin
            conv_code = CODE_NEG_FS;
         end else begin
            conv_code = code_scaled[15:0];
         end
      end
   end

   // previous result stays readable through power-down
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         result_r <= RESULT_RST;
      end else if (conv_done) begin
         result_r.data <= conv_code;
         result_r.valid <= start_valid_r;
      end
   end

   assign busy = (state_r == ST_CONV);
   assign core_powered = (state_r == ST_CONV);
   // front end tracks while idle and again late in the conversion
   assign acquiring = (state_r == ST_DOWN) || (conv_cnt_r >= ACQ_START_CYCLES);
   assign init_done = init_done_r;
   assign result = result_r;

   // delays follow the package counts, so a retimed clock keeps them true
   localparam int CONV_M1 = int'(CONV_CYCLES) - 1;
   localparam int ACQ_M1 = int'(ACQ_START_CYCLES) - 1;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   property start_edge_p;
      cnv_rise && !busy |=> busy && core_powered && !acquiring;
   endproperty
   start_edge_a: assert property (start_edge_p)
      else $error("strobe edge did not start a conversion");

   no_restart_a: assert property (busy && cnv_rise && !conv_done |=> busy && conv_cnt_r == $past(conv_cnt_r) + 8'h01)
      else $error("conversion restarted by strobe edge");

   busy_length_a: assert property ($rose(busy) |-> ##CONV_M1 busy ##1 !busy)
      else $error("busy length differs from conversion time");

   busy_steady_a: assert property ($rose(busy) |-> busy [*8])
      else $error("busy dropped early in conversion");

   power_down_a: assert property ($fell(busy) |-> !core_powered && acquiring)
      else $error("no power down after conversion");

   acq_start_a: assert property ($rose(busy) |-> ##ACQ_M1 !acquiring ##1 acquiring)
      else $error("acquisition restart at wrong time");

   result_latch_a: assert property ($fell(busy) |-> result.data == $past(conv_code))
      else $error("result not latched at busy fall");

   result_hold_a: assert property (!$fell(busy) |-> $stable(result))
      else $error("result changed outside busy fall");

   compress_fs_a: assert property (!held_sel_r && !held_code_r[15] && held_code_r >= 16'h6667 |-> conv_code == CODE_POS_FS)
      else $error("compressed full scale not reached");

   sign_keep_a: assert property (busy |-> conv_code[15] == held_code_r[15])
      else $error("code sign flipped");

   init_wait_a: assert property ($rose(init_done) |-> init_cnt_r == POR_WAIT_CYCLES)
      else $error("init wait length wrong");

   early_invalid_a: assert property ($fell(busy) && !$past(start_valid_r) |-> !result.valid)
      else $error("early conversion marked valid");

   conv_done_c: cover property ($fell(busy) && result.valid);
   ignored_edge_c: cover property (busy && cnv_rise && !conv_done);
   compress_c: cover property ($fell(busy) && !held_sel_r);
   early_conv_c: cover property ($rose(busy) && !init_done);

endmodule // sacc_ctrl

/* sacc_host.sv */
`timescale 1ns/100ps
module sacc_host
   import sacc_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // pins toward the converter
   output logic convert_strobe,
   output logic gain_compress_select
);
   initial begin
      convert_strobe = 1'b0;
      gain_compress_select = 1'b1;
   end
   // select settles well before the edge so both sync stages see it
   task automatic start(input logic sel, input logic extra);
      @(posedge ref_clk);
      gain_compress_select <= sel;
      repeat (3) @(posedge ref_clk);
      convert_strobe <= 1'b1;
      repeat (3) @(posedge ref_clk);
      convert_strobe <= 1'b0;
      if (extra) begin
         // deliberate mid-conversion edge, only when asked
         repeat (20) @(posedge ref_clk);
         convert_strobe <= 1'b1;
         repeat (3) @(posedge ref_clk);
         convert_strobe <= 1'b0;
      end
   endtask
endmodule // sacc_host

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top
   import sacc_pkg::*;
;
   // odd codes reach the rounding, 6666/6667 sit either side of saturation
   localparam logic [15:0] CODES [6] = '{16'h1003, 16'h7000, 16'hF001, 16'h8000, 16'h6666, 16'h6667};
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] sample_code = 16'h0000;
   logic busy, core_powered, acquiring, init_done, convert_strobe, gain_compress_select;
   sacc_result_t result;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   always #5 ref_clk = ~ref_clk;
   sacc_ctrl uut (.ref_clk(ref_clk), .rst(rst), .convert_strobe(convert_strobe),
      .gain_compress_select(gain_compress_select), .sample_code(sample_code), .busy(busy),
      .core_powered(core_powered), .acquiring(acquiring), .init_done(init_done), .result(result));
   sacc_host host (.ref_clk(ref_clk), .convert_strobe(convert_strobe),
      .gain_compress_select(gain_compress_select));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   function automatic logic [15:0] squeeze(input logic [15:0] c);
      int s;
      s = (signed'(c) * 5) >>> 2;
      if (s > SUM_POS_FS)
         return CODE_POS_FS;
      if (s < SUM_NEG_FS)
         return CODE_NEG_FS;
      return 16'(s);
   endfunction
   task automatic conv(input logic sel, input logic [15:0] code, input logic extra, input logic valid);
      int nb;
      int na;
      int np;
      logic held;
      logic [15:0] prev;
      nb = 0;
      na = 0;
      np = 0;
      held = 1'b1;
      prev = result.data;
      @(posedge ref_clk);
      sample_code <= code;
      fork
         host.start(sel, extra);
      join_none
      for (int w = 0; w < 40 && busy !== 1'b1; w++)
         @(negedge ref_clk);
      while (busy === 1'b1 && nb < 300) begin
         nb++;
         na += (acquiring === 1'b0);
         np += (core_powered === 1'b1);
         held &= (result.data === prev);
         @(negedge ref_clk);
      end
      chk("busy cycles", 16'(CONV_CYCLES), 16'(nb));
      chk("powered cycles", 16'(CONV_CYCLES), 16'(np));
      chk("acquire gap", 16'(ACQ_START_CYCLES), 16'(na));
      chk("powered after", 16'h0000, 16'(core_powered));
      chk("acquiring after", 16'h0001, 16'(acquiring));
      chk("result held", 16'h0001, 16'(held));
      chk("result data", sel ? code : squeeze(code), result.data);
      chk("result valid", 16'(valid), 16'(result.valid));
   endtask
   task automatic t_reset();
      int r0;
      @(negedge ref_clk);
      chk("busy in reset", 16'h0000, 16'(busy));
      chk("acquiring in reset", 16'h0001, 16'(acquiring));
      chk("init in reset", 16'h0000, 16'(init_done));
      chk("result in reset", 16'h0000, result.data);
      @(posedge ref_clk);
      rst <= 1'b0;
      r0 = cyc;
      conv(1'b1, 16'h1234, 1'b0, 1'b0);
      wait (cyc == r0 + 1990);
      @(negedge ref_clk);
      chk("init early", 16'h0000, 16'(init_done));
      wait (cyc == r0 + 2010);
      @(negedge ref_clk);
      chk("init done", 16'h0001, 16'(init_done));
      $display("test reset done");
   endtask
   task automatic t_codes();
      for (int i = 0; i < 6; i++) begin
         conv(1'b1, CODES[i], 1'b0, 1'b1);
         conv(1'b0, CODES[i], 1'b0, 1'b1);
      end
      $display("test codes done");
   endtask
   task automatic t_lockout();
      int nh;
      nh = 0;
      conv(1'b1, 16'h2468, 1'b1, 1'b1);
      repeat (200) begin
         @(negedge ref_clk);
         nh += (busy === 1'b1);
      end
      chk("busy after lockout", 16'h0000, 16'(nh));
      $display("test lockout done");
   endtask
   // supply dip in mid-conversion, then the full reinitialisation wait
   task automatic t_brownout();
      int r0;
      fork
         host.start(1'b1, 1'b0);
      join_none
      repeat (40) @(negedge ref_clk);
      chk("busy before brownout", 16'h0001, 16'(busy));
      @(posedge ref_clk);
      rst <= 1'b1;
      @(negedge ref_clk);
      chk("busy in brownout", 16'h0000, 16'(busy));
      chk("powered in brownout", 16'h0000, 16'(core_powered));
      chk("init in brownout", 16'h0000, 16'(init_done));
      chk("result in brownout", 16'h0000, result.data);
      chk("valid in brownout", 16'h0000, 16'(result.valid));
      @(posedge ref_clk);
      rst <= 1'b0;
      r0 = cyc;
      wait (cyc == r0 + 1990);
      @(negedge ref_clk);
      chk("reinit early", 16'h0000, 16'(init_done));
      chk("busy after brownout", 16'h0000, 16'(busy));
      wait (cyc == r0 + 2010);
      @(negedge ref_clk);
      chk("reinit done", 16'h0001, 16'(init_done));
      $display("test brownout done");
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      t_reset();
      t_codes();
      t_lockout();
      t_brownout();
      report_and_stop();
   end
endmodule // tb_top
